/* hdl/tlic_defs.svh */
// constants of the two-level interrupt controller
// assumes inclusion by the package, the top module and the testbench
`ifndef TLIC_DEFS_SVH
`define TLIC_DEFS_SVH
`define TLIC_NSRC 8
`define TLIC_PC_W 16
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_ADDR_CTRL 4'h0
`define TLIC_ADDR_RCTL 4'h1
`define TLIC_ADDR_FLAG 4'h2
`define TLIC_ADDR_EN 4'h3
`define TLIC_ADDR_PRIO 4'h4
`define TLIC_ADDR_PERI 4'h5
`define TLIC_ADDR_STAT 4'h6
`define TLIC_ADDR_MASK 4'h7
`define TLIC_BIT_HIGH 7
`define TLIC_BIT_LOW 6
`define TLIC_BIT_PRIO_EN 7
`define TLIC_INSTR_CYC 4
`define TLIC_LAT_MIN 3
`endif

/* hdl/tlic_pkg.sv */
// types of the two-level interrupt controller
// assumes the defines header is available
`include "tlic_defs.svh"
package tlic_pkg;
    typedef enum logic [1:0] {
        TLIC_IDLE = 2'b00,
        TLIC_WAIT = 2'b01,
        TLIC_TAKE = 2'b11
    } tlic_state_t;
    typedef enum logic [1:0] {
        TLIC_LVL_NONE = 2'b00,
        TLIC_LVL_LOW = 2'b01,
        TLIC_LVL_HIGH = 2'b10
    } tlic_lvl_t;
endpackage : tlic_pkg

/* hdl/tlic_top.sv */
// two-level interrupt controller: flags, enables, priorities, vectoring
// assumes a core that takes vec_take_r as a push-and-jump and signals return
//
// Notes on behaviour
// R1 - each source has flag, enable, priority
// R2 - high vector 0008h, low vector 0018h
// R3 - high request preempts running low service
// R4 - reset control bit 7 enables priority levels
// R5 - priority mode: control bit 7 enables high
// R6 - priority mode: control bit 6 enables low
// R7 - vector when flag, enable, global enable set
// R8 - compatibility mode ignores priority bits
// R9 - compatibility: bit 6 peripherals, bit 7 all
// R10 - compatibility mode always vectors to 0008h
// R11 - acceptance clears the governing global enable
// R12 - no low acceptance during high service
// R13 - accept pushes return, loads vector
// R14 - software clears flags before re-enabling
// R15 - return sets master or level enable
// R16 - external latency three to four cycles
// R17 - flags set regardless of enables
// R18 - software avoids file move on controls
// R19 - simultaneous requests: high first, low pending
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "tlic_defs.svh"
module tlic_top
    import tlic_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [`TLIC_NSRC-1:0] src_event,
    input wire logic [`TLIC_PC_W-1:0] core_pc,
    input wire logic core_instr_start,
    input wire logic core_return,
    output logic vec_take_r,
    output logic [`TLIC_PC_W-1:0] vec_addr_r,
    output logic [`TLIC_PC_W-1:0] push_addr_r,
    output logic in_service_r,
    output logic irq_r
);
    logic [7:0] ctrl_r;
    logic [7:0] rctl_r;
    logic [7:0] flag_r;
    logic [7:0] en_r;
    logic [7:0] prio_r;
    logic [7:0] peri_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic high_act_r;
    logic low_act_r;
    logic [2:0] lat_cnt_r;
    tlic_state_t state_r;
    tlic_lvl_t lvl_r;
    logic [7:0] rdata_nxt;
    wire prio_mode = rctl_r[`TLIC_BIT_PRIO_EN];
    wire wr_ctrl = reg_wr && reg_addr == `TLIC_ADDR_CTRL;
    wire wr_flag = reg_wr && reg_addr == `TLIC_ADDR_FLAG;
    wire rd_stat = reg_rd && reg_addr == `TLIC_ADDR_STAT;
    // R1 qualified sources
    wire [7:0] armed = flag_r & en_r;
    // R8 priority bits only used in priority mode
    wire [7:0] eff_prio = prio_mode ? prio_r : 8'h00;
    // R9 peripheral sources gated by group enable
    wire [7:0] comp_gate = peri_r & {8{ctrl_r[`TLIC_BIT_LOW]}} | ~peri_r;
    // R5 high sources under high global enable
    wire req_high = prio_mode && ctrl_r[`TLIC_BIT_HIGH] && |(armed & eff_prio);
    // R6 low sources; R12 blocked during high service
    wire req_low_p = prio_mode && ctrl_r[`TLIC_BIT_LOW] && |(armed & ~eff_prio)
        && !high_act_r && !low_act_r;
    wire req_comp = !prio_mode && ctrl_r[`TLIC_BIT_HIGH] && |(armed & comp_gate)
        && !high_act_r;
    // R19 high wins, low stays pending
    wire take_high = req_high || req_comp;
    wire take_low = !take_high && req_low_p;
    // R7 request needs flag, enable, global
    wire want = take_high || take_low;
    wire accept = state_r == TLIC_TAKE;
    // R16 wait until instruction boundary after minimum latency
    wire lat_done = lat_cnt_r >= 3'(`TLIC_LAT_MIN) && core_instr_start;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= TLIC_IDLE;
            lat_cnt_r <= 3'd0;
            lvl_r <= TLIC_LVL_NONE;
        end else begin
            unique case (state_r)
                TLIC_IDLE: begin
                    lat_cnt_r <= 3'd1;
                    if (want) begin
                        state_r <= TLIC_WAIT;
                    end
                end
                TLIC_WAIT: begin
                    lat_cnt_r <= lat_cnt_r == 3'd7 ? lat_cnt_r : lat_cnt_r + 3'd1;
                    lvl_r <= take_high ? TLIC_LVL_HIGH : TLIC_LVL_LOW;
                    if (!want) begin
                        state_r <= TLIC_IDLE;
                    end else if (lat_done) begin
                        state_r <= TLIC_TAKE;
                    end
                end
                TLIC_TAKE: begin
                    state_r <= TLIC_IDLE;
                end
                default: state_r <= TLIC_IDLE;
            endcase
        end
    end

    // R13 push return address and jump to vector
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            vec_take_r <= 1'b0;
            vec_addr_r <= `TLIC_VEC_HIGH;
            push_addr_r <= '0;
        end else begin
            vec_take_r <= accept;
            if (accept) begin
                push_addr_r <= core_pc;
                // R2 R10 vector choice; compatibility uses high address
                vec_addr_r <= lvl_r == TLIC_LVL_LOW ? `TLIC_VEC_LOW : `TLIC_VEC_HIGH;
            end
        end
    end

    // R3 service level tracking; high may nest over low
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            high_act_r <= 1'b0;
            low_act_r <= 1'b0;
        end else if (accept) begin
            high_act_r <= high_act_r | (lvl_r == TLIC_LVL_HIGH);
            low_act_r <= low_act_r | (lvl_r == TLIC_LVL_LOW);
        end else if (core_return) begin
            if (high_act_r) begin
                high_act_r <= 1'b0;
            end else begin
                low_act_r <= 1'b0;
            end
        end
    end

    // control register: software writes, R11 clears, R15 sets
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_r <= 8'h00;
        end else if (accept) begin
            // R11 clear governing global enable
            if (prio_mode && lvl_r == TLIC_LVL_LOW) begin
                ctrl_r[`TLIC_BIT_LOW] <= 1'b0;
            end else begin
                ctrl_r[`TLIC_BIT_HIGH] <= 1'b0;
            end
        end else if (core_return) begin
            // R15 re-enable on return
            if (prio_mode && !high_act_r && low_act_r) begin
                ctrl_r[`TLIC_BIT_LOW] <= 1'b1;
            end else begin
                ctrl_r[`TLIC_BIT_HIGH] <= 1'b1;
            end
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata;
        end
    end

    // R4 priority enable, cleared by reset
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rctl_r <= 8'h00;
            en_r <= 8'h00;
            prio_r <= 8'h00;
            peri_r <= 8'h00;
            mask_r <= 2'b00;
        end else if (reg_wr) begin
            if (reg_addr == `TLIC_ADDR_RCTL) rctl_r <= reg_wdata;
            if (reg_addr == `TLIC_ADDR_EN) en_r <= reg_wdata;
            if (reg_addr == `TLIC_ADDR_PRIO) prio_r <= reg_wdata;
            if (reg_addr == `TLIC_ADDR_PERI) peri_r <= reg_wdata;
            if (reg_addr == `TLIC_ADDR_MASK) mask_r <= reg_wdata[1:0];
        end
    end

    // R17 flags set regardless of enables; set wins over write
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flag_r <= 8'h00;
        end else begin
            flag_r <= (wr_flag ? reg_wdata : flag_r) | src_event;
        end
    end

    // sticky status: bit0 high taken, bit1 low taken; read clears, set wins
    wire [1:0] stat_set = {accept && lvl_r == TLIC_LVL_LOW,
        accept && lvl_r != TLIC_LVL_LOW};
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stat_r <= 2'b00;
            irq_r <= 1'b0;
        end else begin
            stat_r <= (rd_stat ? 2'b00 : stat_r) | stat_set;
            irq_r <= |(((rd_stat ? 2'b00 : stat_r) | stat_set) & mask_r);
        end
    end

    always_comb begin
        unique case (reg_addr)
            `TLIC_ADDR_CTRL: rdata_nxt = ctrl_r;
            `TLIC_ADDR_RCTL: rdata_nxt = rctl_r;
            `TLIC_ADDR_FLAG: rdata_nxt = flag_r;
            `TLIC_ADDR_EN: rdata_nxt = en_r;
            `TLIC_ADDR_PRIO: rdata_nxt = prio_r;
            `TLIC_ADDR_PERI: rdata_nxt = peri_r;
            `TLIC_ADDR_STAT: rdata_nxt = {6'h00, stat_r};
            `TLIC_ADDR_MASK: rdata_nxt = {6'h00, mask_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            in_service_r <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
            in_service_r <= high_act_r | low_act_r;
        end
    end

    // R11 global enable cleared after acceptance
    master_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
        accept && !prio_mode |=> !ctrl_r[`TLIC_BIT_HIGH])
        else $error("master enable not cleared on accept");

    // R12 no low accept during high service
    no_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
        high_act_r && accept |-> lvl_r == TLIC_LVL_HIGH)
        else $error("low accepted during high service");

    // R10 compatibility vector
    comp_vec_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
        accept && !prio_mode |=> vec_take_r && vec_addr_r == `TLIC_VEC_HIGH)
        else $error("compatibility vector wrong");

    // R2 low vector
    low_vec_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
        accept && lvl_r == TLIC_LVL_LOW |=> vec_addr_r == `TLIC_VEC_LOW)
        else $error("low vector wrong");

    // R17 flag follows event
    flag_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R17
        src_event[0] |=> flag_r[0])
        else $error("flag not set by event");

    // R13 push address captured
    push_pc_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
        accept |=> push_addr_r == $past(core_pc))
        else $error("return address not pushed");

    // R4 reset state compatibility
    reset_mode_a: assert property (@(posedge clk_sys) // R4
        !reset_n |=> !rctl_r[`TLIC_BIT_PRIO_EN])
        else $error("priority mode not cleared by reset");

    // R15 return re-enables
    ret_en_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R15
        core_return && !accept && !prio_mode |=> ctrl_r[`TLIC_BIT_HIGH])
        else $error("return did not re-enable");

    // R11 high enable cleared
    high_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
        accept && lvl_r == TLIC_LVL_HIGH |=> !ctrl_r[`TLIC_BIT_HIGH])
        else $error("high enable not cleared on accept");

    // R11 low enable cleared
    low_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
        accept && prio_mode && lvl_r == TLIC_LVL_LOW |=> !ctrl_r[`TLIC_BIT_LOW])
        else $error("low enable not cleared on accept");

    // R2 high vector
    high_vec_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
        accept && lvl_r == TLIC_LVL_HIGH |=> vec_addr_r == `TLIC_VEC_HIGH)
        else $error("high vector wrong");

    // R13 single jump pulse
    take_once_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
        vec_take_r |=> !vec_take_r)
        else $error("jump pulse longer than one cycle");

    // R13 jump follows accept
    take_after_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
        accept |=> vec_take_r)
        else $error("accept without jump");

    // R13 no stray jump
    no_stray_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
        !accept |=> !vec_take_r)
        else $error("jump without accept");

    // R16 wait before take
    take_order_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
        state_r == TLIC_TAKE |-> $past(state_r) == TLIC_WAIT)
        else $error("accept without wait");

    // R16 minimum latency counted
    lat_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
        state_r == TLIC_TAKE |-> $past(lat_cnt_r) >= 3'(`TLIC_LAT_MIN))
        else $error("accept before minimum latency");

    // R16 instruction boundary taken
    lat_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
        state_r == TLIC_TAKE |-> $past(core_instr_start))
        else $error("accept off instruction boundary");

    // R16 dropped request abandoned
    wait_drop_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
        state_r == TLIC_WAIT && !want |=> state_r == TLIC_IDLE)
        else $error("dropped request still waiting");

    // R17 every event sets flag
    flag_all_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R17
        |src_event |=> (flag_r & $past(src_event)) == $past(src_event))
        else $error("event flag missing");

    // R1 flag write lands
    flag_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1
        wr_flag |=> flag_r == ($past(reg_wdata) | $past(src_event)))
        else $error("flag write wrong");

    // R8 compatibility level high
    comp_level_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
        !prio_mode && state_r == TLIC_WAIT |=> lvl_r == TLIC_LVL_HIGH)
        else $error("priority bit used in compatibility mode");

    // R9 peripheral group gate
    group_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
        !prio_mode && !ctrl_r[`TLIC_BIT_LOW] && (armed & ~peri_r) == 8'h00 |-> !want)
        else $error("peripheral group not gated");

    // R9 master gate
    master_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
        !prio_mode && !ctrl_r[`TLIC_BIT_HIGH] |-> !want)
        else $error("master enable not gating");

    // R5 high global gate
    high_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5
        prio_mode && !ctrl_r[`TLIC_BIT_HIGH] |-> !take_high)
        else $error("high request without high enable");

    // R6 low global gate
    low_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
        prio_mode && !ctrl_r[`TLIC_BIT_LOW] |-> !take_low)
        else $error("low request without low enable");

    // R7 enable blocks source
    enable_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
        (flag_r & en_r) == 8'h00 |-> !want)
        else $error("request without enabled flag");

    // R19 high chosen first
    high_first_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R19
        req_high && state_r == TLIC_WAIT |=> lvl_r == TLIC_LVL_HIGH)
        else $error("low chosen over high");

    // R3 high service tracked
    high_track_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R3
        accept && lvl_r == TLIC_LVL_HIGH |=> high_act_r)
        else $error("high service not tracked");

    // R15 high level restored
    ret_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R15
        core_return && !accept && prio_mode && high_act_r
        |=> ctrl_r[`TLIC_BIT_HIGH] && !high_act_r)
        else $error("high return did not re-enable");

    // R15 low level restored
    ret_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R15
        core_return && !accept && prio_mode && !high_act_r && low_act_r
        |=> ctrl_r[`TLIC_BIT_LOW] && !low_act_r)
        else $error("low return did not re-enable");
endmodule : tlic_top

/* tb/tlic_core_model.sv */
// core sequencer model: instruction boundaries and program counter
// assumes the controller pulses vec_take_r for one cycle per accept
`timescale 1ns/1ps
module tlic_core_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic vec_take_r,
    input wire logic [15:0] vec_addr_r,
    output logic [15:0] core_pc,
    output logic core_instr_start
);
    // boundary every other cycle, like two-cycle instructions
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            core_pc <= 16'h0100;
            core_instr_start <= 1'b0;
        end else begin
            core_instr_start <= ~core_instr_start;
            core_pc <= vec_take_r ? vec_addr_r : core_pc + 16'h0001;
        end
    end
endmodule : tlic_core_model

/* tb/tlic_top_tb.sv */
// scenario testbench of the two-level interrupt controller
// assumes the core model drives pc and instruction boundaries
`timescale 1ns/1ps
`include "tlic_defs.svh"
module tlic_top_tb;
    import tlic_pkg::*;
    logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, core_return = 0, vec_take_r;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, src_event = 0;
    logic [15:0] core_pc, vec_addr_r, push_addr_r;
    logic core_instr_start, in_service_r, irq_r;
    int n_mismatch = 0, checks_done = 0;
    always #10 clk_sys = ~clk_sys;
    tlic_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_event(src_event), .core_pc(core_pc), .core_instr_start(core_instr_start),
        .core_return(core_return), .vec_take_r(vec_take_r), .vec_addr_r(vec_addr_r),
        .push_addr_r(push_addr_r), .in_service_r(in_service_r), .irq_r(irq_r));
    tlic_core_model core (.clk_sys(clk_sys), .reset_n(reset_n), .vec_take_r(vec_take_r),
        .vec_addr_r(vec_addr_r), .core_pc(core_pc), .core_instr_start(core_instr_start));
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 cmp(what, {8'h00, exp}, {8'h00, reg_rdata});
    endtask : rd
    task automatic pulse(input logic [7:0] m, input logic ret);
        @(posedge clk_sys);
        src_event <= m; core_return <= ret;
        @(posedge clk_sys);
        src_event <= 0; core_return <= 0;
    endtask : pulse
    task automatic take(input logic [15:0] vec);
        int n;
        logic [15:0] pc;
        n = 0;
        while (vec_take_r !== 1'b1 && n < 40) begin
            pc = core_pc;
            @(posedge clk_sys);
            #1 n++;
        end
        cmp("take in time", 1, n >= `TLIC_LAT_MIN + 2 && n <= `TLIC_LAT_MIN + 3);
        cmp("vector", vec, vec_addr_r);
        cmp("pushed pc", pc, push_addr_r);
    endtask : take
    task automatic t_reset;
        rd("ctrl", `TLIC_ADDR_CTRL, 8'h00);
        rd("rctl", `TLIC_ADDR_RCTL, 8'h00);
        rd("unmapped", 4'hf, 8'h00);
        cmp("vec reset", `TLIC_VEC_HIGH, vec_addr_r);
    endtask : t_reset
    task automatic t_flag;
        pulse(8'h05, 0);
        rd("flags", `TLIC_ADDR_FLAG, 8'h05);
        wr(`TLIC_ADDR_FLAG, 8'h00);
        rd("flags clr", `TLIC_ADDR_FLAG, 8'h00);
    endtask : t_flag
    task automatic t_compat;
        wr(`TLIC_ADDR_EN, 8'h01); wr(`TLIC_ADDR_PRIO, 8'h01); wr(`TLIC_ADDR_MASK, 8'h03);
        wr(`TLIC_ADDR_CTRL, 8'h80);
        pulse(8'h01, 0);
        take(`TLIC_VEC_HIGH);
        rd("master off", `TLIC_ADDR_CTRL, 8'h00);
        cmp("irq", 1, irq_r);
        rd("status", `TLIC_ADDR_STAT, 8'h01);
        cmp("irq clr", 0, irq_r);
        wr(`TLIC_ADDR_FLAG, 8'h00);
        pulse(8'h00, 1);
        rd("master back", `TLIC_ADDR_CTRL, 8'h80);
        wr(`TLIC_ADDR_EN, 8'h00);
        pulse(8'h01, 0);
        repeat (20) @(posedge clk_sys);
        #1 cmp("blocked", 0, in_service_r);
        wr(`TLIC_ADDR_FLAG, 8'h00);
    endtask : t_compat
    task automatic t_group;
        wr(`TLIC_ADDR_PERI, 8'h01); wr(`TLIC_ADDR_EN, 8'h01);
        pulse(8'h01, 0);
        repeat (10) @(posedge clk_sys);
        rd("group held", `TLIC_ADDR_STAT, 8'h00);
        wr(`TLIC_ADDR_CTRL, 8'hc0);
        take(`TLIC_VEC_HIGH);
        rd("group off", `TLIC_ADDR_CTRL, 8'h40);
        rd("group stat", `TLIC_ADDR_STAT, 8'h01);
        wr(`TLIC_ADDR_FLAG, 8'h00);
        pulse(8'h00, 1);
        rd("group back", `TLIC_ADDR_CTRL, 8'hc0);
        wr(`TLIC_ADDR_PERI, 8'h00);
    endtask : t_group
    task automatic t_prio;
        // control writes by plain register writes only
        wr(`TLIC_ADDR_CTRL, 8'h00); wr(`TLIC_ADDR_RCTL, 8'h80);
        wr(`TLIC_ADDR_EN, 8'h03); wr(`TLIC_ADDR_PRIO, 8'h02);
        wr(`TLIC_ADDR_CTRL, 8'hc0);
        pulse(8'h03, 0);
        take(`TLIC_VEC_HIGH);
        rd("high off", `TLIC_ADDR_CTRL, 8'h40);
        repeat (20) @(posedge clk_sys);
        #1 cmp("no low", 0, vec_take_r);
        rd("no low stat", `TLIC_ADDR_STAT, 8'h01);
        wr(`TLIC_ADDR_FLAG, 8'h01);
        pulse(8'h00, 1);
        take(`TLIC_VEC_LOW);
        rd("low off", `TLIC_ADDR_CTRL, 8'h80);
        pulse(8'h02, 0);
        take(`TLIC_VEC_HIGH);
        wr(`TLIC_ADDR_FLAG, 8'h00);
        pulse(8'h00, 1);
        pulse(8'h00, 1);
        rd("both back", `TLIC_ADDR_CTRL, 8'hc0);
    endtask : t_prio
    task automatic end_sim;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1;
        t_reset(); t_flag(); t_compat(); t_group(); t_prio();
        end_sim();
    end
endmodule : tlic_top_tb
